// ==== src/timer16_pkg.sv ====
package timer16_pkg;
  localparam int          CNT_W        = 16;
  localparam int          NUM_CH       = 2;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_COUNT    = 8'h04;
  localparam logic [7:0]  OFS_CMPA     = 8'h08;
  localparam logic [7:0]  OFS_CMPB     = 8'h0C;
  localparam logic [7:0]  OFS_CAPTOP   = 8'h10;
  localparam logic [7:0]  OFS_FLAGS    = 8'h14;
  // control field positions
  localparam int          CTL_MODE_LSB = 0;
  localparam int          CTL_COM_LSB  = 4;
  localparam int          CTL_DIR_LSB  = 8;
  localparam int          CTL_W        = 10;
  // flag bit positions
  localparam int          FLG_OVF      = 0;
  localparam int          FLG_CMP0     = 1;
  localparam int          FLG_CAP      = 3;
  localparam int          FLG_W        = 4;
  // waveform modes
  localparam logic [3:0]  MODE_NORMAL  = 4'h0;
  localparam logic [3:0]  MODE_CTC_A   = 4'h4;
  localparam logic [3:0]  MODE_FPWM8   = 4'h5;
  localparam logic [3:0]  MODE_FPWM9   = 4'h6;
  localparam logic [3:0]  MODE_FPWM10  = 4'h7;
  localparam logic [3:0]  MODE_CTC_CAP = 4'hC;
  localparam logic [3:0]  MODE_FPWM_CP = 4'hE;
  localparam logic [3:0]  MODE_FPWM_A  = 4'hF;
  // counter values
  localparam logic [15:0] TOP_8BIT     = 16'h00FF;
  localparam logic [15:0] TOP_9BIT     = 16'h01FF;
  localparam logic [15:0] TOP_10BIT    = 16'h03FF;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM   = 16'h0000;
  // compare output actions
  localparam logic [1:0]  COM_NONE     = 2'h0;
  localparam logic [1:0]  COM_TOGGLE   = 2'h1;
  localparam logic [1:0]  COM_CLEAR    = 2'h2;
  localparam logic [1:0]  COM_SET      = 2'h3;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } apb_state_t;
endpackage : timer16_pkg

// ==== src/timer16_mode_sequencer.sv ====
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module timer16_mode_sequencer (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // timer clock enable from prescaler
  input  wire logic        timer_tick,
  // compare output pins, channel 0 is A
  output logic      [1:0]  compare_output,
  output logic      [1:0]  compare_output_oe_n
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] res_mask(input logic [3:0] m);
    unique case (m)
      timer16_pkg::MODE_FPWM8:  res_mask = timer16_pkg::TOP_8BIT;
      timer16_pkg::MODE_FPWM9:  res_mask = timer16_pkg::TOP_9BIT;
      timer16_pkg::MODE_FPWM10: res_mask = timer16_pkg::TOP_10BIT;
      default:                  res_mask = timer16_pkg::CNT_MAX;
    endcase
  endfunction : res_mask

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  timer16_pkg::apb_state_t state_r;
  logic [9:0]  ctrl_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] captop_r;
  logic [15:0] cmp_buf_r [2];
  logic [15:0] cmp_act_r [2];
  logic [1:0]  oc_r;
  logic [3:0]  flags_r;
  logic [3:0]  flags_nxt;
  logic        block_r;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire        access   = psel & penable;
  wire        wr_take  = access & pready & pwrite;
  wire        hit_ctrl = paddr == timer16_pkg::OFS_CTRL;
  wire        hit_cnt  = paddr == timer16_pkg::OFS_COUNT;
  wire        hit_ca   = paddr == timer16_pkg::OFS_CMPA;
  wire        hit_cb   = paddr == timer16_pkg::OFS_CMPB;
  wire        hit_top  = paddr == timer16_pkg::OFS_CAPTOP;
  wire        hit_flg  = paddr == timer16_pkg::OFS_FLAGS;
  wire        mapped   = hit_ctrl | hit_cnt | hit_ca | hit_cb
                         | hit_top | hit_flg;
  wire        wr_count = wr_take & hit_cnt;
  wire [1:0]  wr_cmp   = {wr_take & hit_cb, wr_take & hit_ca};
  wire [15:0] wdata16  = pwdata[15:0];
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl)
      rd_mux[9:0] = ctrl_r;
    if (hit_cnt)
      rd_mux[15:0] = count_r;
    if (hit_ca)
      rd_mux[15:0] = cmp_buf_r[0];
    if (hit_cb)
      rd_mux[15:0] = cmp_buf_r[1];
    if (hit_top)
      rd_mux[15:0] = captop_r;
    if (hit_flg)
      rd_mux[3:0] = flags_r;
  end

  // one wait state: answer lands on the second access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= timer16_pkg::ST_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      unique case (state_r)
        timer16_pkg::ST_IDLE: begin
          if (access) begin
            state_r <= timer16_pkg::ST_ACK;
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
          end
        end
        timer16_pkg::ST_ACK: begin
          state_r <= timer16_pkg::ST_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // mode only
  wire [3:0]  mode     = ctrl_r[timer16_pkg::CTL_MODE_LSB +: 4];
  wire        is_ctc   = (mode == timer16_pkg::MODE_CTC_A)
                         | (mode == timer16_pkg::MODE_CTC_CAP);
  wire        is_fpwm  = (mode == timer16_pkg::MODE_FPWM8)
                         | (mode == timer16_pkg::MODE_FPWM9)
                         | (mode == timer16_pkg::MODE_FPWM10)
                         | (mode == timer16_pkg::MODE_FPWM_CP)
                         | (mode == timer16_pkg::MODE_FPWM_A);
  wire        cap_top  = (mode == timer16_pkg::MODE_CTC_CAP)
                         | (mode == timer16_pkg::MODE_FPWM_CP);
  wire        a_top    = (mode == timer16_pkg::MODE_CTC_A)
                         | (mode == timer16_pkg::MODE_FPWM_A);
  wire [15:0] top_val  = cap_top ? captop_r
                       : a_top   ? cmp_act_r[0]
                       : res_mask(mode);
  wire        top_hit  = (count_r == top_val) & ~block_r;
  wire        clr_top  = (is_ctc | is_fpwm) & top_hit;
  wire        at_max   = count_r == timer16_pkg::CNT_MAX;
  wire [1:0]  match;

  // ----------------------------------------------------------------
  // counter and blocking
  // ----------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    if (wr_count)
      count_nxt = wdata16;
    else if (timer_tick)
      count_nxt = clr_top ? timer16_pkg::CNT_BOTTOM : count_r + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= timer16_pkg::CNT_BOTTOM;
      block_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      if (wr_count)
        block_r <= 1'b1;
      else if (timer_tick)
        block_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // compare channels
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < timer16_pkg::NUM_CH; ch++) begin : g_ch
      wire [1:0]  com  = ctrl_r[timer16_pkg::CTL_COM_LSB + 2*ch +: 2];
      wire [15:0] wval = wdata16 & res_mask(mode);
      wire        load = timer_tick & is_fpwm & clr_top;
      wire        tgl  = (com == timer16_pkg::COM_TOGGLE)
                         & (~is_fpwm | (ch == 0 && mode ==
                                        timer16_pkg::MODE_FPWM_A));
      assign match[ch] = (count_r == cmp_act_r[ch]) & ~block_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_buf_r[ch] <= timer16_pkg::CNT_BOTTOM;
          cmp_act_r[ch] <= timer16_pkg::CNT_BOTTOM;
          oc_r[ch]      <= 1'b0;
        end else begin
          if (wr_cmp[ch])
            cmp_buf_r[ch] <= wval;
          if (wr_cmp[ch] & ~is_fpwm)
            cmp_act_r[ch] <= wval;
          else if (load)
            cmp_act_r[ch] <= cmp_buf_r[ch];
          if (timer_tick) begin
            if (is_fpwm & clr_top & com == timer16_pkg::COM_CLEAR)
              oc_r[ch] <= 1'b1;
            else if (is_fpwm & clr_top & com == timer16_pkg::COM_SET)
              oc_r[ch] <= 1'b0;
            else if (match[ch] & tgl)
              oc_r[ch] <= ~oc_r[ch];
            else if (match[ch] & com == timer16_pkg::COM_CLEAR)
              oc_r[ch] <= 1'b0;
            else if (match[ch] & com == timer16_pkg::COM_SET)
              oc_r[ch] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // flags, set beats write-one-to-clear
  // ----------------------------------------------------------------
  wire [3:0] flag_clr = (wr_take & hit_flg) ? pwdata[3:0] : 4'h0;
  logic [3:0] flag_set;
  always_comb begin
    flag_set = 4'h0;
    flag_set[timer16_pkg::FLG_OVF] = timer_tick
                                     & (is_fpwm ? clr_top : at_max);
    flag_set[timer16_pkg::FLG_CMP0 +: 2] = timer_tick ? match : 2'b00;
    flag_set[timer16_pkg::FLG_CAP] = timer_tick & cap_top & clr_top;
  end
  assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r              <= 10'h000;
      captop_r            <= timer16_pkg::CNT_BOTTOM;
      flags_r             <= 4'h0;
      compare_output      <= 2'b00;
      compare_output_oe_n <= 2'b11;
    end else begin
      flags_r <= flags_nxt;
      if (wr_take & hit_ctrl)
        ctrl_r <= pwdata[9:0];
      if (wr_take & hit_top)
        captop_r <= wdata16;
      compare_output <= oc_r;
      compare_output_oe_n <= ~ctrl_r[timer16_pkg::CTL_DIR_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  wire [1:0] com_a = ctrl_r[timer16_pkg::CTL_COM_LSB +: 2];
  wire [1:0] com_b = ctrl_r[timer16_pkg::CTL_COM_LSB + 2 +: 2];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_normal_wrap: assert property (
    timer_tick & ~wr_count & mode == timer16_pkg::MODE_NORMAL & at_max
    |=> count_r == timer16_pkg::CNT_BOTTOM)
    else $error("normal mode did not wrap");
  a_ovf_at_zero: assert property (
    timer_tick & ~wr_count & mode == timer16_pkg::MODE_NORMAL & at_max
    |=> flags_r[timer16_pkg::FLG_OVF] & count_r == 16'h0000)
    else $error("overflow flag not set at zero");
  a_ovf_sticky: assert property (
    flags_r[timer16_pkg::FLG_OVF] & ~(wr_take & hit_flg)
    |=> flags_r[timer16_pkg::FLG_OVF])
    else $error("overflow flag dropped by hardware");
  a_ctc_clear: assert property (
    timer_tick & ~wr_count & mode == timer16_pkg::MODE_CTC_A
    & count_r == cmp_act_r[0] & ~block_r |=> count_r == 16'h0000)
    else $error("ctc did not clear at compare a");
  a_cmp_flag: assert property (
    timer_tick & match[0] |=> flags_r[timer16_pkg::FLG_CMP0])
    else $error("compare flag a missing");
  a_write_block: assert property (
    wr_count ##1 (~wr_count)[*1] |-> match == 2'b00)
    else $error("match not blocked after count write");
  a_buf_load: assert property (
    timer_tick & is_fpwm & clr_top & ~wr_cmp[0]
    |=> cmp_act_r[0] == $past(cmp_buf_r[0]))
    else $error("compare a buffer not loaded at top");
  a_pwm_bottom: assert property (
    timer_tick & ~wr_count & mode == timer16_pkg::MODE_FPWM8 & clr_top
    & com_a == timer16_pkg::COM_CLEAR |=> oc_r[0] ##1 compare_output[0])
    else $error("pwm output not set at bottom");
  a_hold_idle: assert property (
    ~timer_tick & ~wr_count |=> $stable(count_r))
    else $error("counter moved without tick");
  a_pin_dir: assert property (
    ~ctrl_r[timer16_pkg::CTL_DIR_LSB] |=> compare_output_oe_n[0])
    else $error("pin driven without direction bit");
  a_pin_dir_b: assert property (
    ~ctrl_r[timer16_pkg::CTL_DIR_LSB + 1] |=> compare_output_oe_n[1])
    else $error("pin b driven without direction bit");
  a_ctc_toggle: assert property (
    timer_tick & is_ctc & match[0] & com_a == timer16_pkg::COM_TOGGLE
    |=> oc_r[0] != $past(oc_r[0]))
    else $error("ctc output a did not toggle");
  a_cap_clear: assert property (
    timer_tick & ~wr_count & mode == timer16_pkg::MODE_CTC_CAP
    & count_r == captop_r & ~block_r
    |=> count_r == timer16_pkg::CNT_BOTTOM)
    else $error("ctc did not clear at capture top");
  // overflow still counts the wrap when a low top was missed
  a_ctc_ovf: assert property (
    timer_tick & is_ctc & at_max
    |=> flags_r[timer16_pkg::FLG_OVF])
    else $error("ctc overflow flag missing");
  a_fpwm_top: assert property (
    timer_tick & ~wr_count & is_fpwm & clr_top
    |=> count_r == timer16_pkg::CNT_BOTTOM & flags_r[timer16_pkg::FLG_OVF])
    else $error("fast pwm did not clear and flag at top");
  a_fpwm_count: assert property (
    timer_tick & ~wr_count & is_fpwm & ~clr_top
    |=> count_r == $past(count_r) + 16'h0001)
    else $error("fast pwm count did not step");
  a_cap_flag: assert property (
    timer_tick & cap_top & clr_top |=> flags_r[timer16_pkg::FLG_CAP])
    else $error("capture flag missing at top");
  a_cmp_flag_b: assert property (
    timer_tick & match[1] |=> flags_r[timer16_pkg::FLG_CMP0 + 1])
    else $error("compare flag b missing");
  a_mask_fixed: assert property (
    wr_cmp[1] & mode == timer16_pkg::MODE_FPWM8
    |=> (cmp_buf_r[1] & ~timer16_pkg::TOP_8BIT) == 16'h0000)
    else $error("compare write not masked to top");
  // no buffering outside fast pwm, so a low top can be skipped
  a_direct_write: assert property (
    wr_cmp[0] & ~is_fpwm |=> cmp_act_r[0] == $past(wdata16))
    else $error("compare a write not applied at once");
  a_hold_none_a: assert property (
    com_a == timer16_pkg::COM_NONE |=> oc_r[0] == $past(oc_r[0]))
    else $error("output a moved with no action");
  a_hold_none_b: assert property (
    com_b == timer16_pkg::COM_NONE |=> oc_r[1] == $past(oc_r[1]))
    else $error("output b moved with no action");

  c_ctc_toggle: cover property (
    timer_tick & is_ctc & match[0] & com_a == timer16_pkg::COM_TOGGLE);
  c_fpwm_top: cover property (timer_tick & is_fpwm & clr_top & cap_top);
  c_flag_race: cover property (flag_set[0] & flag_clr[0]);
  c_ctc_wrap: cover property (timer_tick & is_ctc & at_max);
  c_pwm_invert: cover property (
    timer_tick & is_fpwm & match[0] & com_a == timer16_pkg::COM_SET);
endmodule : timer16_mode_sequencer
`default_nettype wire

// ==== tb/timer16_mode_sequencer_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  bad_count++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module timer16_mode_sequencer_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, timer_tick;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic [1:0]  compare_output, compare_output_oe_n;
  int          bad_count, n_compared, cyc;
  // reference model state
  logic [15:0] mc, mcap, ma[2], mb[2];
  logic [3:0]  mm, fl;
  logic [1:0]  mact[2], oc;
  logic        blk;
  logic [3:0]  modes[8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF};

  timer16_mode_sequencer u_timer16_mode_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
    .compare_output(compare_output),
    .compare_output_oe_n(compare_output_oe_n));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  function automatic logic fp(logic [3:0] m);
    return m inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
  endfunction : fp

  function automatic logic [15:0] topof(logic [3:0] m);
    case (m)
      4'h4, 4'hF: return ma[0];
      4'hC, 4'hE: return mcap;
      4'h5:       return 16'h00FF;
      4'h6:       return 16'h01FF;
      4'h7:       return 16'h03FF;
      default:    return 16'hFFFF;
    endcase
  endfunction : topof

  // one timer step; a pending count write swallows this step's matches
  function automatic void step();
    logic f, hit;
    f   = fp(mm);
    hit = (f || mm == 4'h4 || mm == 4'hC) && mc == topof(mm) && !blk;
    for (int ch = 0; ch < 2; ch++) begin
      if (!blk && mc == ma[ch]) begin
        fl[1+ch] = 1'b1;
        if (mact[ch] == 2'h1 && (!f || (ch == 0 && mm == 4'hF)))
          oc[ch] = ~oc[ch];
        else if (mact[ch][1]) oc[ch] = mact[ch][0];
      end
    end
    if (hit && (mm == 4'hC || mm == 4'hE)) fl[3] = 1'b1;
    if (f ? hit : mc == 16'hFFFF) fl[0] = 1'b1;
    if (hit && f) begin
      ma = mb;
      for (int ch = 0; ch < 2; ch++)
        if (mact[ch][1]) oc[ch] = ~mact[ch][0];
    end
    mc  = hit ? 16'h0000 : mc + 16'h0001;
    blk = 1'b0;
  endfunction : step

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench cycle limit ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string nm);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    `chk(nm, x, q)
    `chk("slverr", 1'b0, e)
  endtask : rd

  // buffered in fast pwm, masked to the fixed resolution
  task automatic wcmp(input int ch, input logic [15:0] v);
    wr(ch ? timer16_pkg::OFS_CMPB : timer16_pkg::OFS_CMPA, {16'h0, v});
    if (mm inside {4'h5, 4'h6, 4'h7}) v &= topof(mm);
    mb[ch] = v;
    if (!fp(mm)) ma[ch] = v;
  endtask : wcmp

  task automatic run(input int n);
    repeat (n) begin
      @(posedge pclk);
      if (timer_tick) step();
      timer_tick <= 1'($urandom);
    end
    @(posedge pclk);
    if (timer_tick) step();
    timer_tick <= 1'b0;
  endtask : run

  initial begin
    logic [31:0] q;
    logic        e;
    logic [15:0] t, tp, st, na, bb;
    logic [1:0]  aa, ab, dir;
    int          r;
    {psel, penable, pwrite, timer_tick, presetn} = 5'h0;
    paddr = 8'h00; pwdata = 32'h0;
    {mc, mcap, mm, fl, oc, blk} = '0;
    ma = '{16'h0, 16'h0}; mb = ma; mact = '{2'h0, 2'h0};
    void'($urandom(32'h2EA15EF7));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, "reset reg");
    `chk("oe_n", 2'h3, compare_output_oe_n)
    apb(1'b0, 8'h18, 32'h0, q, e);
    `chk("bad addr err", 1'b1, e)
    `chk("bad addr data", 32'h0, q)
    apb(1'b1, 8'h1C, 32'hFFFF, q, e);
    `chk("bad addr wr err", 1'b1, e)
    for (int i = 0; i < 40; i++) begin
      t  = 16'(3 + $urandom % 30);
      tp = (modes[i%8] inside {4'h4, 4'hC, 4'hE, 4'hF}) ? t
           : topof(modes[i%8]);
      aa = 2'((i / 8) % 4);
      ab = 2'($urandom);
      dir = 2'($urandom);
      r  = $urandom % 3;
      st = r == 0 ? 16'($urandom % tp) : r == 1 ? tp - 16'(1 + $urandom % 3)
           : 16'hFFF0 + 16'($urandom % 14);
      wr(timer16_pkg::OFS_CTRL, 32'h0);
      mm = 4'h0;
      wr(timer16_pkg::OFS_FLAGS, 32'hF);
      fl = 4'h0;
      wcmp(0, (modes[i%8] inside {4'h4, 4'hF}) ? t
              : 16'($urandom % (32'(tp) + 1)));
      wcmp(1, 16'($urandom % (32'(tp) + 1)));
      wr(timer16_pkg::OFS_CAPTOP, {16'h0, t});
      mcap = t;
      wr(timer16_pkg::OFS_COUNT, {16'h0, st});
      mc = st; blk = 1'b1;
      wr(timer16_pkg::OFS_CTRL, 32'({dir, ab, aa, modes[i%8]}));
      mm = modes[i%8]; mact[0] = aa; mact[1] = ab;
      run(30 + $urandom % 50);
      // register tops stay legal; in modes E and F compares stay under them
      na = (modes[i%8] == 4'hE) ? 16'($urandom % (32'(t) + 1))
           : 16'(3 + $urandom % 30);
      bb = (modes[i%8] == 4'hF && na < t) ? na : t;
      bb = (modes[i%8] inside {4'hE, 4'hF})
           ? 16'($urandom % (32'(bb) + 1)) : 16'($urandom);
      wcmp(1, bb);
      wcmp(0, na);
      run(30 + $urandom % 50);
      rd(timer16_pkg::OFS_COUNT, mc, "count");
      rd(timer16_pkg::OFS_FLAGS, fl, "flags");
      rd(timer16_pkg::OFS_CMPA, mb[0], "cmp a");
      rd(timer16_pkg::OFS_CMPB, mb[1], "cmp b");
      `chk("out", oc, compare_output)
      `chk("oe_n", ~dir, compare_output_oe_n)
    end
    tally_and_finish();
  end
endmodule : timer16_mode_sequencer_tb_top
`default_nettype wire
